// [design/lcr_pkg.sv]
package lcr_pkg;
    // cells in one tile group, chain order cell 0 first
    localparam int CELLS_PER_TILE = 10;
    localparam int LUT_BITS       = 16;
    localparam int LUT_INPUTS     = 4;
    // bit positions inside a 16-bit arithmetic table word
    localparam int SUM0_LSB       = 0;
    localparam int SUM1_LSB       = 4;
    localparam int CY0_LSB        = 8;
    localparam int CY1_LSB        = 12;
    localparam int SUB_LUT_BITS   = 4;
    // register input source codes
    localparam logic [1:0] SRC_COMB  = 2'h0;
    localparam logic [1:0] SRC_CHAIN = 2'h1;
    localparam logic [1:0] SRC_D3    = 2'h2;
    localparam logic [1:0] SRC_ZERO  = 2'h3;
    // clear selects per tile: two clears plus none
    localparam logic [1:0] CLR_NONE  = 2'h0;
    localparam logic [1:0] CLR_A     = 2'h1;
    localparam logic [1:0] CLR_B     = 2'h2;
    // synchroniser idle levels: pin bits high, tile clears and preset low
    localparam logic [4:0] SYNC_IDLE = 5'h11;

    // cell operating mode, one-hot
    typedef enum logic [1:0] {
        LCR_NORMAL = 2'b01,
        LCR_ARITH  = 2'b10
    } lcr_mode_t;

    // per-cell configuration bits
    typedef struct packed {
        lcr_mode_t                mode;
        logic [LUT_BITS-1:0]      table_bits;
        logic                     use_carry_in;  // table input 3 from carry, at chain end only
        logic                     chain_end;     // cell ends an adder chain
        logic                     use_lut_chain; // input 0 from previous cell
        logic [1:0]               reg_src;
        logic [1:0]               clr_sel;
        logic                     preset_en;
        logic                     aload_en;
        logic                     power_up_high;
    } lcr_cell_cfg_t;

    // per-cell data inputs
    typedef struct packed {
        logic [LUT_INPUTS-1:0]    data;
    } lcr_cell_in_t;
endpackage

// [design/lcr_tile.sv]
`timescale 1ns/10ps
// asynchronous controls are sampled into mclk (two flops) and applied
// as a priority override on the next edge; a real cell would act at once.
module lcr_tile #(
    parameter int N = lcr_pkg::CELLS_PER_TILE
) (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         reset_n,
    // per-cell configuration and data
    input  wire lcr_pkg::lcr_cell_cfg_t [N-1:0] cell_cfg,
    input  wire lcr_pkg::lcr_cell_in_t  [N-1:0] cell_in,
    // tile controls
    input  wire logic                         tile_clear_a,
    input  wire logic                         tile_clear_b,
    input  wire logic                         tile_preset,
    input  wire logic                         tile_carry_in,
    input  wire logic                         subtract,
    input  wire logic                         first_in_row,
    // chains from the previous tile
    input  wire logic                         reg_chain_in,
    // chip-wide clear pin and its option
    input  wire logic                         clr_pin_en,
    input  wire logic                         global_register_clear_pin_in,
    input  wire logic                         user_pin_out,
    input  wire logic                         user_pin_oe,
    output logic                              global_register_clear_pin_out,
    output logic                              global_register_clear_pin_oe,
    output logic                              user_pin_in,
    // cell outputs
    output logic [N-1:0]                      comb_out,
    output logic [N-1:0]                      reg_out,
    output logic                              carry_out
);
    // sampled asynchronous-origin inputs
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] next_sync1;
    logic       pin_clr, clr_a, clr_b, preset, aload_d3;
    logic [N-1:0] comb_v;
    logic [N-1:0] next_reg;
    logic [N:0]   cy0;
    logic [N:0]   cy1;
    logic [N-1:0] next_comb;
    logic         next_carry;
    logic         next_pin_out, next_pin_oe, next_user_in;
    logic [N-1:0] reg_q;
    logic         started;
    logic         cin_sel;

    // four-input table lookup for normal mode; arithmetic mode uses lut2
    function automatic logic lut4(input logic [15:0] t, input logic [3:0] a);
        lut4 = t[a];
    endfunction

    // slice one 2-input table out of the arithmetic word
    function automatic logic lut2(input logic [15:0] t, input int lsb,
                                  input logic a, input logic b);
        logic [3:0] s;
        s = t[lsb +: lcr_pkg::SUB_LUT_BITS];
        lut2 = s[{a, b}];
    endfunction

    // synchroniser inputs: pin, clear a, clear b, preset, pin raw
    always_comb begin
        next_sync1 = {global_register_clear_pin_in, tile_clear_a, tile_clear_b,
                      tile_preset, global_register_clear_pin_in};
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            // idle levels, so no clear or preset is seen just after reset
            sync1 <= lcr_pkg::SYNC_IDLE;
            sync2 <= lcr_pkg::SYNC_IDLE;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
        end
    end

    assign pin_clr  = clr_pin_en & ~sync2[4];
    assign clr_a    = sync2[3];
    assign clr_b    = sync2[2];
    assign preset   = sync2[1];

    // chain origin: a row start takes the direction bit
    assign cin_sel = first_in_row ? subtract : tile_carry_in;

    // ten cells share the tile controls and chains
    // per-cell combinational datapath
    always_comb begin
        next_comb = '0;
        cy0       = '0;
        cy1       = '0;
        // chain 0 assumes no carry in, chain 1 assumes one
        cy0[0]    = 1'b0;
        cy1[0]    = 1'b1;
        for (int i = 0; i < N; i++) begin
            logic [3:0] a;
            logic       x, y, s0, s1, sel;
            a   = '0;
            x   = 1'b0;
            y   = 1'b0;
            s0  = 1'b0;
            s1  = 1'b0;
            sel = 1'b0;
            // tile carry-in picks which chain reaches this cell
            sel = cin_sel ? cy1[i] : cy0[i];
            a   = cell_in[i].data;
            if (cell_cfg[i].use_lut_chain && i > 0)
                a[0] = next_comb[i-1];
            // carry as table input only at chain end
            if (cell_cfg[i].use_carry_in && cell_cfg[i].chain_end)
                a[3] = sel;
            x = a[1];
            y = a[2] ^ subtract;
            case (cell_cfg[i].mode)
                lcr_pkg::LCR_NORMAL: begin
                    next_comb[i] = lut4(cell_cfg[i].table_bits, a);
                    cy0[i+1]     = cy0[i];
                    cy1[i+1]     = cy1[i];
                end
                lcr_pkg::LCR_ARITH: begin
                    s0       = lut2(cell_cfg[i].table_bits, lcr_pkg::SUM0_LSB, x, y);
                    s1       = lut2(cell_cfg[i].table_bits, lcr_pkg::SUM1_LSB, x, y);
                    // chosen chain level picks the sum
                    next_comb[i] = sel ? s1 : s0;
                    // both chains ripple side by side, each through its own carry
                    if (cy0[i])
                        cy0[i+1] = lut2(cell_cfg[i].table_bits, lcr_pkg::CY1_LSB, x, y);
                    else
                        cy0[i+1] = lut2(cell_cfg[i].table_bits, lcr_pkg::CY0_LSB, x, y);
                    if (cy1[i])
                        cy1[i+1] = lut2(cell_cfg[i].table_bits, lcr_pkg::CY1_LSB, x, y);
                    else
                        cy1[i+1] = lut2(cell_cfg[i].table_bits, lcr_pkg::CY0_LSB, x, y);
                end
                default: begin
                    next_comb[i] = 1'b0;
                    cy0[i+1]     = cy0[i];
                    cy1[i+1]     = cy1[i];
                end
            endcase
        end
        // carry leaves the tile on the chosen chain
        next_carry = cin_sel ? cy1[N] : cy0[N];
    end

    // register next values with priority: pin clear, tile clear, preset, load, clock
    always_comb begin
        next_reg = reg_q;
        for (int i = 0; i < N; i++) begin
            logic clr;
            logic din;
            clr = 1'b0;
            din = 1'b0;
            clr = (cell_cfg[i].clr_sel == lcr_pkg::CLR_A && clr_a) ||
                  (cell_cfg[i].clr_sel == lcr_pkg::CLR_B && clr_b);
            case (cell_cfg[i].reg_src)
                lcr_pkg::SRC_COMB:  din = next_comb[i];
                lcr_pkg::SRC_CHAIN: din = (i == 0) ? reg_chain_in : reg_q[i-1];
                // packing: register fed from input independent of table
                lcr_pkg::SRC_D3:    din = cell_in[i].data[3];
                default:            din = 1'b0;
            endcase
            if (pin_clr)
                next_reg[i] = 1'b0;
            else if (clr)
                next_reg[i] = 1'b0;
            else if (cell_cfg[i].preset_en && preset)
                next_reg[i] = 1'b1;
            else if (cell_cfg[i].aload_en && preset && cell_cfg[i].mode == lcr_pkg::LCR_NORMAL)
                next_reg[i] = cell_in[i].data[3];
            else
                next_reg[i] = din;
        end
        // ordinary pin when option is off
        next_pin_out = user_pin_out;
        next_pin_oe  = ~clr_pin_en & user_pin_oe;
        next_user_in = sync2[0];
    end

    // power-up state per register, caught after reset release
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_q    <= '0;
            started  <= 1'b0;
            comb_out <= '0;
            carry_out <= 1'b0;
            global_register_clear_pin_out <= 1'b0;
            global_register_clear_pin_oe  <= 1'b0;
            user_pin_in <= 1'b0;
        end else begin
            started  <= 1'b1;
            reg_q    <= started ? next_reg : reg_init(cell_cfg);
            comb_out <= next_comb;
            carry_out <= next_carry;
            global_register_clear_pin_out <= next_pin_out;
            global_register_clear_pin_oe  <= next_pin_oe;
            user_pin_in <= next_user_in;
        end
    end

    assign reg_out = reg_q;

    // power-up image of the configured register states
    function automatic logic [N-1:0] reg_init(input lcr_pkg::lcr_cell_cfg_t [N-1:0] c);
        for (int i = 0; i < N; i++)
            reg_init[i] = c[i].power_up_high;
    endfunction


    // chip clear clears every register next edge
    AST_PIN_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
        started && pin_clr |=> reg_q == '0) else $error("chip clear missed");
    AST_CLR_WINS: assert property (@(posedge mclk) disable iff (!reset_n)
        started && clr_a && preset && cell_cfg[0].clr_sel == lcr_pkg::CLR_A |=> !reg_q[0])
        else $error("preset beat clear");
    AST_CLR_B: assert property (@(posedge mclk) disable iff (!reset_n)
        started && clr_b && cell_cfg[1].clr_sel == lcr_pkg::CLR_B |=> !reg_q[1])
        else $error("second clear missed");
    AST_PRESET: assert property (@(posedge mclk) disable iff (!reset_n)
        started && !pin_clr && preset && cell_cfg[2].preset_en && cell_cfg[2].clr_sel == lcr_pkg::CLR_NONE
        |=> reg_q[2]) else $error("preset did not load high");
    AST_LOAD_D3: assert property (@(posedge mclk) disable iff (!reset_n)
        started && !pin_clr && preset && cell_cfg[3].aload_en && !cell_cfg[3].preset_en
        && cell_cfg[3].clr_sel == lcr_pkg::CLR_NONE && cell_cfg[3].mode == lcr_pkg::LCR_NORMAL
        |=> reg_q[3] == $past(cell_in[3].data[3])) else $error("load value not the fourth input");
    // packed register fed apart from the table
    AST_PACKING: assert property (@(posedge mclk) disable iff (!reset_n)
        started && !pin_clr && cell_cfg[5].reg_src == lcr_pkg::SRC_D3 && cell_cfg[5].clr_sel == lcr_pkg::CLR_NONE
        && !cell_cfg[5].preset_en && !cell_cfg[5].aload_en
        |=> reg_q[5] == $past(cell_in[5].data[3])) else $error("packed register wrong");
    // power-up values land on the first edge
    AST_POWER_UP: assert property (@(posedge mclk) disable iff (!reset_n)
        !started ##1 started
        |-> reg_q[1:0] == {$past(cell_cfg[1].power_up_high), $past(cell_cfg[0].power_up_high)})
        else $error("power-up state wrong");
    AST_SHIFT: assert property (@(posedge mclk) disable iff (!reset_n)
        started && !pin_clr && cell_cfg[1].reg_src == lcr_pkg::SRC_CHAIN
        && cell_cfg[1].clr_sel == lcr_pkg::CLR_NONE
        && !cell_cfg[1].preset_en && !cell_cfg[1].aload_en |=> reg_q[1] == $past(reg_q[0]))
        else $error("chain shift wrong");
    AST_PIN_OE: assert property (@(posedge mclk) disable iff (!reset_n)
        clr_pin_en |=> !global_register_clear_pin_oe) else $error("pin driven as clear");
    // user drive passes when option off
    AST_USER_OE: assert property (@(posedge mclk) disable iff (!reset_n)
        !clr_pin_en |=> global_register_clear_pin_oe == $past(user_pin_oe))
        else $error("user drive enable lost");
    AST_COMB: assert property (@(posedge mclk) disable iff (!reset_n)
        cell_cfg[1].mode == lcr_pkg::LCR_NORMAL && cell_cfg[1].use_lut_chain && !cell_cfg[1].use_carry_in
        |=> comb_out[1] == $past(cell_cfg[1].table_bits[{cell_in[1].data[3:1], next_comb[0]}]))
        else $error("lut chain input wrong");
    // carry ignored away from a chain end
    AST_NO_CARRY: assert property (@(posedge mclk) disable iff (!reset_n)
        cell_cfg[3].mode == lcr_pkg::LCR_NORMAL && cell_cfg[3].use_carry_in && !cell_cfg[3].chain_end
        && !cell_cfg[3].use_lut_chain |=> comb_out[3] == $past(cell_cfg[3].table_bits[cell_in[3].data]))
        else $error("carry used away from chain end");
    AST_PIN_SYNC: assert property (@(posedge mclk) disable iff (!reset_n)
        !global_register_clear_pin_in ##2 clr_pin_en |-> pin_clr)
        else $error("pin clear not seen");
    // a carry made in both chains of the last cell leaves the tile
    AST_CARRY: assert property (@(posedge mclk) disable iff (!reset_n)
        cell_cfg[N-1].mode == lcr_pkg::LCR_ARITH && cell_in[N-1].data[1] && (cell_in[N-1].data[2] ^ subtract)
        && cell_cfg[N-1].table_bits[lcr_pkg::CY0_LSB + lcr_pkg::SUB_LUT_BITS - 1]
        && cell_cfg[N-1].table_bits[lcr_pkg::CY1_LSB + lcr_pkg::SUB_LUT_BITS - 1]
        |=> carry_out) else $error("carry out wrong");
endmodule // lcr_tile

// [tb/lcr_fabric_model.sv]
`timescale 1ns/10ps
// far side: last register of the previous tile and the board at the clear pin
module lcr_fabric_model (
    // clock
    input  wire logic mclk,
    // board controls from the bench
    input  wire logic hold_clear,
    input  wire logic shift_bit,
    // device drive of the pin
    input  wire logic pin_out,
    input  wire logic pin_oe,
    // toward the tile
    output logic      pin_level,
    output logic      reg_chain_in
);
    // board holds clear low
    // pull-up on the board, so a released pin reads high, never the last value
    always_comb begin
        if (hold_clear) begin
            pin_level = 1'b0;
        end else if (pin_oe) begin
            pin_level = pin_out;
        end else begin
            pin_level = 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        reg_chain_in <= shift_bit;
    end
endmodule // lcr_fabric_model

// [tb/test_logic_cell_lut_carry_register.sv]
`timescale 1ns/10ps
// self-checking bench for one tile of ten cells
module test_logic_cell_lut_carry_register;
    localparam int N = lcr_pkg::CELLS_PER_TILE;
    logic                              mclk;
    logic                              reset_n;
    lcr_pkg::lcr_cell_cfg_t [N-1:0]    cell_cfg;
    lcr_pkg::lcr_cell_in_t  [N-1:0]    cell_in;
    logic                              clr_a, clr_b, preset, cy_in, sub, first;
    logic                              chain_in, pin_en, pin_level, hold, shift_bit;
    logic                              u_out, u_oe, p_out, p_oe, u_in, carry_out;
    logic [N-1:0]                      comb_out, reg_out;
    int                                bad_count, n_tests;

    lcr_tile #(.N(N)) DUT (.mclk(mclk), .reset_n(reset_n), .cell_cfg(cell_cfg), .cell_in(cell_in),
        .tile_clear_a(clr_a), .tile_clear_b(clr_b), .tile_preset(preset), .tile_carry_in(cy_in),
        .subtract(sub), .first_in_row(first), .reg_chain_in(chain_in), .clr_pin_en(pin_en),
        .global_register_clear_pin_in(pin_level), .user_pin_out(u_out), .user_pin_oe(u_oe),
        .global_register_clear_pin_out(p_out), .global_register_clear_pin_oe(p_oe),
        .user_pin_in(u_in), .comb_out(comb_out), .reg_out(reg_out), .carry_out(carry_out));
    lcr_fabric_model fabric (.mclk(mclk), .hold_clear(hold), .shift_bit(shift_bit), .pin_out(p_out),
        .pin_oe(p_oe), .pin_level(pin_level), .reg_chain_in(chain_in));

    // clock, 40 ns period
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic lcr_pkg::lcr_cell_cfg_t plain(input logic [15:0] tbl, input logic [1:0] src);
        lcr_pkg::lcr_cell_cfg_t c;
        c = '0;
        c.mode = lcr_pkg::LCR_NORMAL;
        c.table_bits = tbl;
        c.reg_src = src;
        return c;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // async controls go through a synchroniser, so give them room
    task automatic settle();
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic t_powerup();
        repeat (3) @(posedge mclk);
        #1;
        check("reg_out in reset", reg_out, 0);
        @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        #1;
        check("power-up state", reg_out, 32'h155);
        settle();
        check("clocked zero source", reg_out, 0);
    endtask

    // and-table chained cells, carry as table input only at a chain end
    task automatic t_lut();
        @(posedge mclk);
        for (int i = 0; i < N; i++) begin
            cell_cfg[i] <= plain(16'h8000, lcr_pkg::SRC_COMB);
            cell_in[i] <= '0;
        end
        cell_cfg[0].use_carry_in <= 1'b1;
        cell_cfg[0].chain_end <= 1'b1;
        cell_cfg[1].use_lut_chain <= 1'b1;
        cell_cfg[3].use_carry_in <= 1'b1;
        cell_cfg[4].table_bits <= 16'hfffe;
        cell_cfg[5].reg_src <= lcr_pkg::SRC_D3;
        cell_in[0] <= 4'hf;
        cell_in[1] <= 4'he;
        cell_in[3] <= 4'hf;
        cell_in[5] <= 4'h8;
        cy_in <= 1'b0;
        settle();
        check("comb carry 0", comb_out, 32'h008);
        check("reg carry 0", reg_out, 32'h028);
        @(posedge mclk);
        cy_in <= 1'b1;
        settle();
        check("comb carry 1", comb_out, 32'h00b);
        check("reg carry 1", reg_out, 32'h02b);
    endtask

    task automatic t_arith(input logic [9:0] a, input logic [9:0] b, input logic c, input logic s,
                           input logic f);
        logic [10:0] r;
        r = {1'b0, a} + {1'b0, (s ? ~b : b)} + 11'((f ? s : c));
        @(posedge mclk);
        for (int i = 0; i < N; i++) begin
            cell_cfg[i] <= plain(16'he896, lcr_pkg::SRC_COMB);
            cell_cfg[i].mode <= lcr_pkg::LCR_ARITH;
            cell_in[i] <= {1'b0, b[i], a[i], 1'b0};
        end
        cy_in <= c;
        sub <= s;
        first <= f;
        settle();
        check("sum", comb_out, r[9:0]);
        check("chain carry", carry_out, r[10]);
        check("registered sum", reg_out, r[9:0]);
    endtask

    task automatic t_ctrl(input logic ca, input logic cb, input logic pr, input logic en,
                          input logic hd, input logic [9:0] exp);
        @(posedge mclk);
        clr_a <= ca;
        clr_b <= cb;
        preset <= pr;
        pin_en <= en;
        hold <= hd;
        settle();
        check("reg_out controls", reg_out, exp);
    endtask

    task automatic t_shift();
        int k;
        @(posedge mclk);
        for (int i = 0; i < N; i++) begin
            cell_cfg[i] <= plain(16'h0000, lcr_pkg::SRC_CHAIN);
        end
        settle();
        @(posedge mclk);
        shift_bit <= 1'b1;
        @(posedge mclk);
        shift_bit <= 1'b0;
        k = 0;
        while (reg_out[0] !== 1'b1) begin
            @(posedge mclk);
            #1;
            k++;
            if (k > 20) begin
                bad_count++;
                close_out();
            end
        end
        for (int j = 1; j < N; j++) begin
            @(posedge mclk);
            #1;
            check("shift stage", reg_out, 32'(1 << j));
        end
    endtask

    initial begin
        bad_count = 0;
        n_tests = 0;
        reset_n = 1'b0;
        {clr_a, clr_b, preset, cy_in, sub, first, pin_en, hold, shift_bit, u_out, u_oe} = '0;
        cell_in = '0;
        for (int i = 0; i < N; i++) begin
            cell_cfg[i] = plain(16'h0000, lcr_pkg::SRC_ZERO);
            cell_cfg[i].power_up_high = ~i[0];
        end
        t_powerup();
        t_lut();
        t_arith(10'h3ff, 10'h001, 1'b0, 1'b0, 1'b0);
        t_arith(10'h155, 10'h0aa, 1'b1, 1'b0, 1'b0);
        t_arith(10'h100, 10'h001, 1'b0, 1'b1, 1'b1);
        t_arith(10'h000, 10'h001, 1'b0, 1'b1, 1'b1);
        t_arith(10'h2aa, 10'h155, 1'b1, 1'b1, 1'b0);
        // clears on cells 0 and 1, preset on 0 and 2, load of input 3 on 3 and 4
        @(posedge mclk);
        for (int i = 0; i < N; i++) begin
            cell_cfg[i] <= plain(16'hfffe, lcr_pkg::SRC_COMB);
            cell_in[i] <= 4'h1;
        end
        cell_cfg[0].clr_sel <= lcr_pkg::CLR_A;
        cell_cfg[0].preset_en <= 1'b1;
        cell_cfg[1].clr_sel <= lcr_pkg::CLR_B;
        cell_cfg[2].preset_en <= 1'b1;
        cell_cfg[3].aload_en <= 1'b1;
        cell_cfg[3].reg_src <= lcr_pkg::SRC_ZERO;
        cell_cfg[4].aload_en <= 1'b1;
        cell_in[2] <= 4'h0;
        cell_in[3] <= 4'h8;
        t_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h3f3);
        t_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 10'h3f2);
        t_ctrl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 10'h3f1);
        t_ctrl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 10'h3ef);
        t_ctrl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 10'h3ee);
        t_ctrl(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 10'h000);
        // option off: pin is a plain user pin and clears nothing
        t_ctrl(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 10'h3ee);
        check("user pin low", u_in, 1'b0);
        @(posedge mclk);
        hold <= 1'b0;
        u_oe <= 1'b1;
        settle();
        check("user drive enable", p_oe, 1'b1);
        check("user drive level", p_out, 1'b0);
        check("user pin driven", u_in, 1'b0);
        @(posedge mclk);
        pin_en <= 1'b1;
        settle();
        check("no drive with option on", p_oe, 1'b0);
        check("user pin released", u_in, 1'b1);
        t_shift();
        close_out();
    end
endmodule // test_logic_cell_lut_carry_register
